/* File: design/servo_mode_pkg.sv */
package servo_mode_pkg;

    // ----------------------------------------------------------------
    // Widths and counts
    // ----------------------------------------------------------------
    localparam int SPEED_WIDTH = 16;
    localparam int ADDR_WIDTH = 8;
    localparam int SETTING_COUNT = 7;
    localparam int PIN_COUNT = 8;

    // ----------------------------------------------------------------
    // Register byte offsets
    // ----------------------------------------------------------------
    localparam logic [7:0] REG_CONTROL = 8'h00;
    localparam logic [7:0] REG_ACCEL = 8'h04;
    localparam logic [7:0] REG_DECEL = 8'h08;
    localparam logic [7:0] REG_ZERO_LEVEL = 8'h0C;
    localparam logic [7:0] REG_REACH_WINDOW = 8'h10;
    localparam logic [7:0] REG_STATUS = 8'h14;
    localparam logic [7:0] REG_SETTING_FIRST = 8'h20;
    localparam logic [7:0] REG_SETTING_LAST = 8'h38;

    // ----------------------------------------------------------------
    // Control register fields and mode digits
    // ----------------------------------------------------------------
    localparam int CTRL_DIGIT_LSB = 0;
    localparam int CTRL_ABS_BIT = 4;
    localparam int CTRL_THIRD_BIT = 5;
    localparam logic [3:0] DIGIT_POS_SPEED = 4'h1;
    localparam logic [3:0] DIGIT_SPEED_TORQUE = 4'h3;
    localparam logic [3:0] DIGIT_TORQUE_POS = 4'h5;

    // ----------------------------------------------------------------
    // Reset values
    // ----------------------------------------------------------------
    localparam logic [5:0] CONTROL_RESET = 6'h00;
    localparam logic [15:0] ACCEL_RESET = 16'h0010;
    localparam logic [15:0] DECEL_RESET = 16'h0010;
    localparam logic [15:0] ZERO_LEVEL_RESET = 16'h0032;
    localparam logic [15:0] REACH_WINDOW_RESET = 16'h0014;
    localparam logic [15:0] SETTING_RESET = 16'h0000;

    // ----------------------------------------------------------------
    // Control modes, one-hot
    // ----------------------------------------------------------------
    typedef enum logic [2:0] {
        MODE_POSITION = 3'b001,
        MODE_SPEED = 3'b010,
        MODE_TORQUE = 3'b100
    } control_mode_type;

endpackage

/* File: design/speed_ramp.sv */
module speed_ramp
    import servo_mode_pkg::*;
#(
    parameter int WIDTH = SPEED_WIDTH
) (
    // Clock and reset.
    input wire logic clock,
    input wire logic rst,
    // Target and time constants; a unit step takes the time constant plus one clock cycles.
    input wire logic signed [WIDTH-1:0] target,
    input wire logic [15:0] accelTime,
    input wire logic [15:0] decelTime,
    // Ramped reference.
    output logic signed [WIDTH-1:0] current
);

    if (WIDTH < 8) begin : width_check
        $error("speed_ramp needs at least 8 bits of speed");
    end

    logic [15:0] stepCount;
    logic speedingUp;
    logic [15:0] period;
    logic stepNow;

    // Moving away from zero accelerates; moving toward zero decelerates.
    assign speedingUp = (target > current) ? (current >= 0) : (current <= 0);
    assign period = speedingUp ? accelTime : decelTime;
    assign stepNow = (stepCount >= period);

    // Step divider, restarted whenever a step is taken or the target is met.
    always_ff @(posedge clock) begin
        if (rst || stepNow || target == current) begin
            stepCount <= 16'h0000;
        end else begin
            stepCount <= stepCount + 16'h0001;
        end
    end

    // One unit per step toward the target, so speed changes during rotation ramp.
    always_ff @(posedge clock) begin
        if (rst) begin
            current <= '0;
        end else if (stepNow && target > current) begin
            current <= current + WIDTH'(1);
        end else if (stepNow && target < current) begin
            current <= current - WIDTH'(1);
        end
    end

    ramp_step_a: assert property (@(posedge clock) disable iff (rst)
        (current != $past(current)) |->
            (current - $past(current) == WIDTH'(1)
             || $past(current) - current == WIDTH'(1)))
        else $error("ramp moved more than one unit");

endmodule // speed_ramp

/* File: design/servo_mode_switch.sv */
// Function
// - Digit 1 selects position/speed change mode.
// - Absolute position system disables position/speed mode.
// - Position/speed pair: select off position, on speed.
// - Position pairs accept toggles only at zero speed.
// - Toggle made above zero speed stays ignored.
// - Position to speed clears droop pulses.
// - Two select bits: analog, settings one to three.
// - Third bit assigned: analog, settings one to seven.
// - Speed changes ramp with accel/decel constants.
// - Speed/torque pair: select off speed, on torque.
// - Speed/torque change applies immediately at any speed.
// - Starts off in speed mode: decelerate to stop.
// - Speed limit in torque, speed/torque pair: bit0 off analog, on setting one.
// - Digit 5: off torque, on position.
// - Position to torque clears droop pulses.
// - Any alarm shuts the power stage off at once.
// - Power cycle, panel set, reset edge clear alarms.
// - Alarm stays while its cause persists.
// - Speed reached flag near commanded speed.
// - Speed limiting flag at speed limit in torque.
//
// Local design decisions: the APB interface to the registers and the address map.
module servo_mode_switch
    import servo_mode_pkg::*;
#(
    parameter int WIDTH = SPEED_WIDTH
) (
    // Clock and reset; reset doubles as the control-power cycle.
    input wire logic clock,
    input wire logic rst,
    // APB slave.
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_WIDTH-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Contact inputs from the external controller, asynchronous.
    input wire logic modeSelectInput,
    input wire logic speedSelectBit0,
    input wire logic speedSelectBit1,
    input wire logic speedSelectBit2,
    input wire logic forwardStartInput,
    input wire logic reverseStartInput,
    input wire logic servoOnInput,
    input wire logic alarmResetInput,
    // Drive-internal values on this clock.
    input wire logic signed [WIDTH-1:0] motorSpeed,
    input wire logic signed [WIDTH-1:0] analogSpeedCommand,
    input wire logic signed [WIDTH-1:0] analogSpeedLimit,
    input wire logic alarmCause,
    input wire logic panelSetPress,
    // Drive-internal results.
    output control_mode_type controlMode,
    output logic droopClear,
    output logic signed [WIDTH-1:0] speedReference,
    output logic [WIDTH-1:0] speedLimit,
    output logic zeroSpeedFlag,
    output logic speedReachedFlag,
    output logic speedLimitingFlag,
    output logic alarmActive,
    output logic baseDriveEnable
);

    if (WIDTH < 8 || WIDTH > 16) begin : width_check
        $error("servo_mode_switch supports 8 to 16 speed bits");
    end

    default clocking cb @(posedge clock);
    endclocking
    default disable iff (rst);

    function automatic logic [WIDTH-1:0] magnitude(input logic signed [WIDTH-1:0] value);
        magnitude = (value < 0) ? WIDTH'(-value) : WIDTH'(value);
    endfunction

    // ----------------------------------------------------------------
    // Contact input synchronisers
    // ----------------------------------------------------------------
    logic [PIN_COUNT-1:0] pinMeta;
    logic [PIN_COUNT-1:0] pinSync;
    logic modeSelPrev;
    logic resetPrev;
    logic modeSelSync;
    logic resetSync;
    logic [2:0] selectSync;
    logic fwdSync;
    logic revSync;
    logic servoOnSync;

    // Two stages on every contact; only the second stage is read.
    always_ff @(posedge clock) begin
        if (rst) begin
            pinMeta <= '0;
            pinSync <= '0;
        end else begin
            pinMeta <= {alarmResetInput, servoOnInput, reverseStartInput, forwardStartInput,
                        speedSelectBit2, speedSelectBit1, speedSelectBit0,
                        modeSelectInput};
            pinSync <= pinMeta;
        end
    end

    assign modeSelSync = pinSync[0];
    assign selectSync = pinSync[3:1];
    assign fwdSync = pinSync[4];
    assign revSync = pinSync[5];
    assign servoOnSync = pinSync[6];
    assign resetSync = pinSync[7];

    // Previous levels for edge detection on the synchronised inputs.
    always_ff @(posedge clock) begin
        if (rst) begin
            modeSelPrev <= 1'b0;
            resetPrev <= 1'b0;
        end else begin
            modeSelPrev <= modeSelSync;
            resetPrev <= resetSync;
        end
    end

    // ----------------------------------------------------------------
    // Registers
    // ----------------------------------------------------------------
    logic [5:0] controlReg;
    logic [15:0] accelTime;
    logic [15:0] decelTime;
    logic [15:0] zeroLevel;
    logic [15:0] reachWindow;
    logic [15:0] speedSetting [SETTING_COUNT];
    logic [3:0] modeDigit;
    logic absSystem;
    logic thirdBit;
    logic writeNow;
    logic settingHit;
    logic [2:0] settingIndex;
    logic mapped;
    logic [31:0] readValue;
    logic selAccepted;

    assign modeDigit = controlReg[CTRL_DIGIT_LSB +: 4];
    assign absSystem = controlReg[CTRL_ABS_BIT];
    assign thirdBit = controlReg[CTRL_THIRD_BIT];
    assign writeNow = psel && penable && pwrite;
    assign settingHit = paddr >= REG_SETTING_FIRST && paddr <= REG_SETTING_LAST
                        && paddr[1:0] == 2'b00;
    assign settingIndex = 3'((paddr - REG_SETTING_FIRST) >> 2);

    // Register writes take effect in the access phase only.
    always_ff @(posedge clock) begin
        if (rst) begin
            controlReg <= CONTROL_RESET;
            accelTime <= ACCEL_RESET;
            decelTime <= DECEL_RESET;
            zeroLevel <= ZERO_LEVEL_RESET;
            reachWindow <= REACH_WINDOW_RESET;
            for (int i = 0; i < SETTING_COUNT; i++) begin
                speedSetting[i] <= SETTING_RESET;
            end
        end else if (writeNow) begin
            if (paddr == REG_CONTROL) controlReg <= pwdata[5:0];
            if (paddr == REG_ACCEL) accelTime <= pwdata[15:0];
            if (paddr == REG_DECEL) decelTime <= pwdata[15:0];
            if (paddr == REG_ZERO_LEVEL) zeroLevel <= pwdata[15:0];
            if (paddr == REG_REACH_WINDOW) reachWindow <= pwdata[15:0];
            if (settingHit) speedSetting[settingIndex] <= pwdata[15:0];
        end
    end

    // Read decode; unmapped addresses read zero and flag an error.
    always_comb begin
        readValue = 32'h0000_0000;
        mapped = 1'b1;
        case (paddr)
            REG_CONTROL: readValue = {26'h0, controlReg};
            REG_ACCEL: readValue = {16'h0, accelTime};
            REG_DECEL: readValue = {16'h0, decelTime};
            REG_ZERO_LEVEL: readValue = {16'h0, zeroLevel};
            REG_REACH_WINDOW: readValue = {16'h0, reachWindow};
            REG_STATUS: readValue = {16'(speedReference), 7'h0, selAccepted, modeSelSync,
                                     speedLimitingFlag, speedReachedFlag, zeroSpeedFlag,
                                     alarmActive, controlMode};
            default: begin
                if (settingHit) begin
                    readValue = {16'h0, speedSetting[settingIndex]};
                end else begin
                    mapped = 1'b0;
                end
            end
        endcase
    end

    // Read data and error are captured in the setup cycle, so every
    // transfer finishes in its first access cycle.
    always_ff @(posedge clock) begin
        if (rst) begin
            prdata <= 32'h0000_0000;
            pslverr <= 1'b0;
        end else if (psel && !penable) begin
            prdata <= pwrite ? 32'h0000_0000 : readValue;
            pslverr <= !mapped;
        end
    end

    assign pready = psel && penable;

    // ----------------------------------------------------------------
    // Control mode selection
    // ----------------------------------------------------------------
    logic pairValid;
    logic needsZero;
    logic modeSelToggle;
    control_mode_type nextMode;

    // Position/speed is refused with the absolute system; other digits hold position.
    assign pairValid = (modeDigit == DIGIT_POS_SPEED && !absSystem)
                       || modeDigit == DIGIT_SPEED_TORQUE
                       || modeDigit == DIGIT_TORQUE_POS;
    assign needsZero = modeDigit != DIGIT_SPEED_TORQUE;
    assign modeSelToggle = modeSelSync != modeSelPrev;
    assign zeroSpeedFlag = magnitude(motorSpeed) <= WIDTH'(zeroLevel);

    // A position-pair toggle away from zero speed is dropped for good: the accepted level
    // only moves on an edge, so a later fall to zero speed does not revive it.
    always_ff @(posedge clock) begin
        if (rst) begin
            selAccepted <= 1'b0;
        end else if (modeSelToggle && (!needsZero || zeroSpeedFlag)) begin
            selAccepted <= modeSelSync;
        end
    end

    always_comb begin
        nextMode = MODE_POSITION;
        if (pairValid) begin
            case (modeDigit)
                DIGIT_POS_SPEED:
                    nextMode = selAccepted ? MODE_SPEED : MODE_POSITION;
                DIGIT_SPEED_TORQUE:
                    nextMode = selAccepted ? MODE_TORQUE : MODE_SPEED;
                DIGIT_TORQUE_POS:
                    nextMode = selAccepted ? MODE_POSITION : MODE_TORQUE;
                default: nextMode = MODE_POSITION;
            endcase
        end
    end

    // Leaving position control resets the droop pulses in the same cycle.
    always_ff @(posedge clock) begin
        if (rst) begin
            controlMode <= MODE_POSITION;
            droopClear <= 1'b0;
        end else begin
            controlMode <= nextMode;
            droopClear <= controlMode == MODE_POSITION
                && nextMode != MODE_POSITION;
        end
    end

    // ----------------------------------------------------------------
    // Speed selection, ramp and limit
    // ----------------------------------------------------------------
    logic [2:0] selectCode;
    logic [WIDTH-1:0] selectedCommand;
    logic [WIDTH-1:0] selectedLimit;
    logic signed [WIDTH-1:0] target;

    // The third bit only counts when it has been assigned to an input.
    assign selectCode = thirdBit ? selectSync : {1'b0, selectSync[1:0]};

    always_comb begin
        if (selectCode == 3'h0) begin
            selectedCommand = magnitude(analogSpeedCommand);
            selectedLimit = magnitude(analogSpeedLimit);
        end else begin
            selectedCommand = WIDTH'(speedSetting[selectCode - 3'h1]);
            selectedLimit = WIDTH'(speedSetting[selectCode - 3'h1]);
        end
    end

    // With both starts off (or both on) the target is zero, so the ramp
    // decelerates to a stop; an alarm also drops the target.
    always_comb begin
        target = '0;
        if (controlMode == MODE_SPEED && !alarmActive) begin
            if (fwdSync && !revSync) begin
                target = selectedCommand;
            end else if (revSync && !fwdSync) begin
                target = -selectedCommand;
            end else begin
                target = '0;
            end
        end
    end

    speed_ramp #(
        .WIDTH(WIDTH)
    ) ramp (
        .clock(clock),
        .rst(rst),
        .target(target),
        .accelTime(accelTime),
        .decelTime(decelTime),
        .current(speedReference)
    );

    // Speed limit in torque control; the speed/torque pair uses bit 0 alone.
    always_ff @(posedge clock) begin
        if (rst) begin
            speedLimit <= '0;
        end else if (modeDigit == DIGIT_SPEED_TORQUE) begin
            speedLimit <= selectSync[0] ? WIDTH'(speedSetting[0])
                                        : magnitude(analogSpeedLimit);
        end else begin
            speedLimit <= selectedLimit;
        end
    end

    // ----------------------------------------------------------------
    // Status flags
    // ----------------------------------------------------------------
    logic signed [WIDTH:0] speedError;

    assign speedError = (WIDTH+1)'(motorSpeed) - (WIDTH+1)'(target);

    always_ff @(posedge clock) begin
        if (rst) begin
            speedReachedFlag <= 1'b0;
            speedLimitingFlag <= 1'b0;
        end else begin
            speedReachedFlag <= controlMode == MODE_SPEED
                && (speedError < 0 ? (WIDTH+1)'(-speedError) : (WIDTH+1)'(speedError))
                   <= (WIDTH+1)'(reachWindow);
            speedLimitingFlag <= controlMode == MODE_TORQUE
                && magnitude(motorSpeed) >= speedLimit;
        end
    end

    // ----------------------------------------------------------------
    // Alarm handling
    // ----------------------------------------------------------------
    logic resetRise;

    assign resetRise = resetSync && !resetPrev;

    // A present cause wins over a panel-set or reset-edge clear request; only rst clears it regardless.
    always_ff @(posedge clock) begin
        if (rst) begin
            alarmActive <= 1'b0;
        end else if (alarmCause) begin
            alarmActive <= 1'b1;
        end else if (panelSetPress || resetRise) begin
            alarmActive <= 1'b0;
        end
    end

    // Kept combinational so the power stage drops in the cycle the cause appears.
    // The controller is still expected to drop servo-on and main power itself.
    assign baseDriveEnable = servoOnSync && !alarmActive && !alarmCause;

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    sequence ignoredToggle;
        modeSelToggle && needsZero && !zeroSpeedFlag;
    endsequence

    sequence quietModeSel;
        !modeSelToggle [*2];
    endsequence

    abs_blocks_a: assert property (modeDigit == DIGIT_POS_SPEED && absSystem
        ##1 $stable(controlReg) |=> controlMode == MODE_POSITION)
        else $error("position/speed mode active with absolute system");

    ps_select_a: assert property (modeDigit == DIGIT_POS_SPEED && !absSystem
        && $stable(controlReg) && $stable(selAccepted)
        |=> controlMode == ($past(selAccepted) ? MODE_SPEED : MODE_POSITION))
        else $error("position/speed selection wrong");

    toggle_ignored_a: assert property (ignoredToggle |=> $stable(selAccepted))
        else $error("toggle accepted above zero speed");

    late_zero_a: assert property (ignoredToggle ##1 quietModeSel
        |-> selAccepted == $past(selAccepted, 3))
        else $error("ignored toggle applied later");

    droop_clear_a: assert property (droopClear == ($past(controlMode) == MODE_POSITION
        && controlMode != MODE_POSITION))
        else $error("droop clear not tied to leaving position");

    st_immediate_a: assert property (modeDigit == DIGIT_SPEED_TORQUE && modeSelToggle
        && $stable(controlReg) |=> selAccepted == $past(modeSelSync)
        ##1 controlMode == ($past(selAccepted) ? MODE_TORQUE : MODE_SPEED))
        else $error("speed/torque change delayed");

    tp_select_a: assert property (modeDigit == DIGIT_TORQUE_POS && $stable(controlReg)
        && $stable(selAccepted) |=> controlMode
            == ($past(selAccepted) ? MODE_POSITION : MODE_TORQUE))
        else $error("torque/position selection wrong");

    start_stop_a: assert property (controlMode == MODE_SPEED && !fwdSync && !revSync
        |-> target == 0)
        else $error("target not zero with starts off");

    decode_a: assert property (controlMode == MODE_SPEED && !alarmActive && fwdSync
        && !revSync && selectCode == 3'h2 |-> target == WIDTH'(speedSetting[1]))
        else $error("speed select decode wrong");

    limit_pick_a: assert property (modeDigit == DIGIT_SPEED_TORQUE && selectSync[0]
        |=> speedLimit == WIDTH'($past(speedSetting[0])))
        else $error("speed limit not setting one");

    alarm_cut_a: assert property (alarmCause |-> !baseDriveEnable ##1 alarmActive)
        else $error("power stage on during alarm");

    alarm_hold_a: assert property (alarmCause |=> alarmActive)
        else $error("alarm cleared with cause present");

    alarm_clear_a: assert property (alarmActive && !alarmCause && resetRise
        |=> !alarmActive)
        else $error("reset edge did not clear alarm");

endmodule // servo_mode_switch

/* File: bench/contact_driver.sv */
module contact_driver (
    // Clock and requests from the bench.
    input wire logic clock,
    input wire logic modeWant,
    input wire logic [2:0] selWant,
    input wire logic startWant,
    input wire logic resetWant,
    input wire logic alarmActive,
    // Contact pins of the drive.
    output logic modeSelectInput,
    output logic speedSelectBit0,
    output logic speedSelectBit1,
    output logic speedSelectBit2,
    output logic forwardStartInput,
    output logic reverseStartInput,
    output logic servoOnInput,
    output logic alarmResetInput
);
    timeunit 1ns;
    timeprecision 1ns;
    // Contacts are open until the first edge.
    initial {modeSelectInput, speedSelectBit0, speedSelectBit1, speedSelectBit2} = 4'h0;
    initial {forwardStartInput, reverseStartInput, servoOnInput, alarmResetInput} = 4'h0;
    // Relays follow the bench a cycle late; an alarm drops run contacts a cycle late too.
    always @(posedge clock) begin
        modeSelectInput <= modeWant;
        {speedSelectBit2, speedSelectBit1, speedSelectBit0} <= selWant;
        forwardStartInput <= startWant & ~alarmActive;
        reverseStartInput <= 1'h0;
        servoOnInput <= ~alarmActive;
        alarmResetInput <= resetWant;
    end
endmodule // contact_driver

/* File: bench/tb.sv */
module tb
    import servo_mode_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic clock = 0, rst = 1, psel = 0, penable = 0, pwrite = 0, pready, pslverr;
    logic [7:0] paddr = 0;
    logic [31:0] pwdata = 0, prdata, rd;
    logic mSel, sb0, sb1, sb2, fwd, rev, servoOn, ares, er, droopSeen;
    logic modeWant = 0, startWant = 0, resetWant = 0, alarmCause = 0, panelSetPress = 0;
    logic [2:0] selWant = 0;
    logic signed [SPEED_WIDTH-1:0] motorSpeed = 0, analogSpeedCommand = 900;
    logic signed [SPEED_WIDTH-1:0] analogSpeedLimit = 0, speedReference;
    logic [SPEED_WIDTH-1:0] speedLimit;
    control_mode_type controlMode;
    logic droopClear, zeroSpeedFlag, speedReachedFlag, speedLimitingFlag, alarmActive, bde;
    int fail_count = 0, tests_run = 0, seed = 32'h66ec;
    int setv[8];
    // Free-running bench clock.
    always #4 clock = ~clock;
    servo_mode_switch u_servo_mode_switch (.clock(clock), .rst(rst), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .modeSelectInput(mSel), .speedSelectBit0(sb0),
        .speedSelectBit1(sb1), .speedSelectBit2(sb2), .forwardStartInput(fwd),
        .reverseStartInput(rev), .servoOnInput(servoOn), .alarmResetInput(ares),
        .motorSpeed(motorSpeed), .analogSpeedCommand(analogSpeedCommand),
        .analogSpeedLimit(analogSpeedLimit), .alarmCause(alarmCause),
        .panelSetPress(panelSetPress), .controlMode(controlMode), .droopClear(droopClear),
        .speedReference(speedReference), .speedLimit(speedLimit),
        .zeroSpeedFlag(zeroSpeedFlag), .speedReachedFlag(speedReachedFlag),
        .speedLimitingFlag(speedLimitingFlag), .alarmActive(alarmActive),
        .baseDriveEnable(bde));
    contact_driver u_contact_driver (.clock(clock), .modeWant(modeWant), .selWant(selWant),
        .startWant(startWant), .resetWant(resetWant), .alarmActive(alarmActive),
        .modeSelectInput(mSel), .speedSelectBit0(sb0), .speedSelectBit1(sb1),
        .speedSelectBit2(sb2), .forwardStartInput(fwd), .reverseStartInput(rev),
        .servoOnInput(servoOn), .alarmResetInput(ares));
    // Compare one result against the model.
    task chk(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            fail_count++;
            $display("BAD %0t %h %h", $time, seen, exp);
        end
    endtask
    // Waits on rising edges, sampling the one-cycle droop pulse before it can vanish.
    task step(input int n);
        repeat (n) begin
            @(posedge clock);
            droopSeen |= droopClear;
        end
    endtask
    // One APB transfer; a spare edge after release keeps strobes from being driven twice.
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        psel <= 1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clock);
        penable <= 1;
        do begin
            @(posedge clock);
        end while (pready !== 1'h1);
        rd = prdata;
        er = pslverr;
        psel <= 0;
        penable <= 0;
        @(posedge clock);
    endtask
    task tally_and_finish;
        if (fail_count == 0 && tests_run > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    // Hang guard, well beyond the roughly 530 cycles the sequence needs.
    initial begin
        repeat (20000) @(posedge clock);
        fail_count++;
        tally_and_finish();
    end
    // ----------------------------------------------------------------
    // Main sequence
    // ----------------------------------------------------------------
    initial begin
        step(8);
        rst <= 0;
        step(3);
        chk(controlMode, MODE_POSITION);
        chk(bde, 1);
        apb(0, 8'hFC, 0);
        chk(er, 1);
        chk(rd, 0);
        for (int k = 1; k < 8; k++) begin
            setv[k] = 100 * k + ($random(seed) & 15);
            apb(1, REG_SETTING_FIRST + 8'(4 * (k - 1)), setv[k]);
        end
        apb(0, REG_SETTING_FIRST + 8'h08, 0);
        chk(rd, setv[3]);
        chk(er, 0);
        apb(1, REG_CONTROL, 1);
        droopSeen = 0;
        modeWant <= 1;
        step(8);
        chk(controlMode, MODE_SPEED);
        chk(droopSeen, 1);
        motorSpeed <= 1000;
        modeWant <= 0;
        step(8);
        chk(controlMode, MODE_SPEED);
        chk(zeroSpeedFlag, 0);
        motorSpeed <= 0;
        step(8);
        chk(controlMode, MODE_SPEED);
        apb(1, REG_CONTROL, 32'h11);
        modeWant <= 1;
        step(8);
        chk(controlMode, MODE_POSITION);
        modeWant <= 0;
        step(8);
        apb(1, REG_CONTROL, 3);
        motorSpeed <= 1000;
        modeWant <= 1;
        analogSpeedLimit <= $random(seed) & 16'h3FFF;
        selWant <= 1;
        step(8);
        chk(controlMode, MODE_TORQUE);
        chk(speedLimit, setv[1]);
        chk(speedLimitingFlag, 1);
        selWant <= 0;
        step(8);
        chk(speedLimit, analogSpeedLimit);
        chk(speedLimitingFlag, 1000 >= analogSpeedLimit);
        modeWant <= 0;
        startWant <= 1;
        step(8);
        chk(controlMode, MODE_SPEED);
        apb(1, REG_CONTROL, 32'h23);
        for (int c = 0; c < 8; c++) begin
            selWant <= c[2:0];
            motorSpeed <= (c == 0) ? 16'sd900 : setv[c][15:0];
            step(8);
            chk(speedReachedFlag, 1);
        end
        apb(1, REG_CONTROL, 3);
        motorSpeed <= setv[3][15:0];
        step(8);
        chk(speedReachedFlag, 1);
        chk(speedReference > 0, 1);
        startWant <= 0;
        step(300);
        chk(speedReference, 0);
        motorSpeed <= 0;
        modeWant <= 1;
        apb(1, REG_CONTROL, 5);
        step(8);
        chk(controlMode, MODE_POSITION);
        droopSeen = 0;
        modeWant <= 0;
        step(8);
        chk(controlMode, MODE_TORQUE);
        chk(droopSeen, 1);
        alarmCause <= 1;
        resetWant <= 1;
        step(1);
        chk(bde, 0);
        step(8);
        chk(alarmActive, 1);
        alarmCause <= 0;
        resetWant <= 0;
        step(4);
        resetWant <= 1;
        step(6);
        chk(alarmActive, 0);
        alarmCause <= 1;
        step(1);
        alarmCause <= 0;
        panelSetPress <= 1;
        step(1);
        panelSetPress <= 0;
        step(2);
        chk(alarmActive, 0);
        tally_and_finish();
    end
endmodule // tb
